// ---- csls_fifo.sv ----
`default_nettype none
module csls_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || WIDTH < 1) begin : gBadParam
    $error("csls_fifo needs DEPTH >= 2 and WIDTH >= 1");
  end

  // shifting buffer: the head is always slot 0, so the output is a flop
  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0]    count;

  wire          push      = inValid & inReady;
  wire          pop       = outValid & outReady;
  wire [CW-1:0] wrPos     = pop ? count - CW'(1) : count;
  wire [CW-1:0] nextCount = count + CW'(push) - CW'(pop);

  assign inReady = count != CW'(DEPTH);
  assign outData = mem[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      count    <= '0;
      outValid <= 1'b0;
    end else begin
      count    <= nextCount;
      outValid <= nextCount != '0;
    end
  end

  always_ff @(posedge clk) begin
    for (int k = 0; k < DEPTH; k++) begin
      if (push && CW'(k) == wrPos) begin
        mem[k] <= inData;
      end else if (pop && k < DEPTH - 1) begin
        mem[k] <= mem[(k < DEPTH - 1) ? k + 1 : k];
      end
    end
  end

endmodule : csls_fifo
`default_nettype wire

// ---- csls_node_model.sv ----
`default_nettype none
module csls_node_model (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // bench control
  input  wire logic               stall,
  // words from the scheduler
  input  wire logic               txValid,
  output logic                    txReady,
  input  wire csls_pkg::csls_tx_s txWord,
  // received values by destination index
  output logic [31:0]             destMem [0:99]
);
  timeunit 1ns;
  timeprecision 1ns;
  import csls_pkg::*;
  logic [1:0] phase;
  // a busy node takes one word in four, so the fifo backs up
  assign txReady = !stall || (phase == 2'h0);
  always_ff @(posedge mclk) begin
    if (rst)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
    // any target accepted, each word to its own destination
    if (txValid && txReady)
      destMem[txWord.dest] <= txWord.data;
  end
endmodule : csls_node_model
`default_nettype wire

// ---- csls_pkg.sv ----
`default_nettype none
package csls_pkg;

  // clock and time base
  localparam int CLK_HZ      = 10_000_000;
  localparam int CYC_PER_US  = CLK_HZ / 1_000_000;
  localparam int TB_1000_US  = 1000;
  localparam int TB_1380_US  = 1380;
  localparam int TB_1840_US  = 1840;
  localparam int TB_2560_US  = 2560;
  localparam int TB_1000_CYC = TB_1000_US * CYC_PER_US;
  localparam int TB_1380_CYC = TB_1380_US * CYC_PER_US;
  localparam int TB_1840_CYC = TB_1840_US * CYC_PER_US;
  localparam int TB_2560_CYC = TB_2560_US * CYC_PER_US;
  localparam int US_PER_MS   = 1000;

  // capacities
  localparam int MAX_LINKS   = 10;
  localparam int MAX_WORDS   = 20;
  localparam int NUM_SRC     = 100;
  localparam int SMALL_LIMIT = 80;
  localparam int LARGE_LIMIT = 100;
  localparam int FIFO_DEPTH  = 8;

  // register map (byte addresses)
  localparam logic [11:0] CTRL_OFS  = 12'h000;
  localparam logic [11:0] RATE_OFS  = 12'h004;
  localparam logic [11:0] STAT_OFS  = 12'h008;
  localparam logic [11:0] LINK_BASE = 12'h040;
  localparam logic [11:0] LINK_END  = 12'h068;
  localparam logic [11:0] SRC_BASE  = 12'h100;
  localparam logic [11:0] SRC_END   = 12'h290;

  // control fields
  localparam int CTRL_SYNC_BIT  = 0;
  localparam int CTRL_TAKE_BIT  = 1;
  localparam int CTRL_SMALL_BIT = 2;
  localparam int CTRL_TB_LSB    = 4;
  localparam int CTRL_FSEL_LSB  = 8;
  localparam int CTRL_LOSS_LSB  = 16;

  // status fields
  localparam int STAT_GEN_BIT     = 0;
  localparam int STAT_LOST_BIT    = 1;
  localparam int STAT_BADLINK_BIT = 2;
  localparam int STAT_OVERRUN_BIT = 3;

  // reset values and descriptor write mask
  localparam logic [7:0]  LOSS_RST  = 8'h64;
  localparam logic [15:0] RATE_RST  = 16'h1005;
  localparam logic [31:0] LINK_MASK = 32'hFF9F_7F7F;

  typedef enum logic [1:0] {
    TB_1MS  = 2'b00,
    TB_SEL  = 2'b01,
    TB_2560 = 2'b10,
    TB_RSV  = 2'b11
  } csls_tb_e;

  typedef struct packed {
    logic [7:0] target;
    logic       slow;
    logic [1:0] rsvA;
    logic [4:0] count;
    logic       rsvB;
    logic [6:0] dest;
    logic       rsvC;
    logic [6:0] src;
  } csls_link_s;

  typedef struct packed {
    logic [7:0]  target;
    logic [6:0]  dest;
    logic        last;
    logic [31:0] data;
  } csls_tx_s;

endpackage : csls_pkg
`default_nettype wire

// ---- csls_sched_assertions.sv ----
`default_nettype none
module csls_sched_assertions (
  // clock and reset
  input wire logic               mclk,
  input wire logic               rst,
  // apb
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [31:0]        prdata,
  // network
  input wire logic               syncIn,
  input wire logic               syncOut,
  input wire logic               txValid,
  input wire logic               txReady,
  input wire csls_pkg::csls_tx_s txWord
);
  timeunit 1ns;
  timeprecision 1ns;
  import csls_pkg::*;
  // saturating age of the last sync event, either direction
  logic [9:0] sinceSync;
  always_ff @(posedge mclk)
    if (rst || syncIn || syncOut)
      sinceSync <= 10'h000;
    else if (sinceSync != 10'h3FF)
      sinceSync <= sinceSync + 10'h001;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (s_access |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_has_cause: assert property (
    pready |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  a_error_reads_zero: assert property (
    pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error response with data");
  a_word_held: assert property (
    txValid && !txReady |=> txValid && $stable(txWord))
    else $error("word changed while stalled");
  a_tx_after_sync: assert property (
    $rose(txValid) |-> sinceSync < 10'h384)
    else $error("word sent without sync");
  a_sync_spacing: assert property (syncOut |=> !syncOut [*4])
    else $error("sync pulses too close");
  a_reset_quiet: assert property (
    $fell(rst) |-> !pready && !syncOut && !txValid)
    else $error("outputs active after reset");
endmodule : csls_sched_assertions
bind csls_scheduler csls_sched_assertions i_csls_sched_assertions (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .syncIn(syncIn), .syncOut(syncOut),
  .txValid(txValid), .txReady(txReady), .txWord(txWord));
`default_nettype wire

// ---- csls_scheduler.sv ----
// Function
// RULE_01: rate is four digits: ratio in high pair, fast ms in low pair.
// RULE_02: selector codes 0, 2 or 4 give a 1.38 ms time base.
// RULE_03: selector codes 1 or 3 give a 1.84 ms time base.
// RULE_04: other bases: fast period is least tick multiple above requested.
// RULE_05: links go out only on sync messages; no sync means no transfers.
// RULE_06: optional takeover: on sync loss this node starts generating sync.
// RULE_07: descriptor holds source, count, slow flag, target node, destination.
// RULE_08: on sync, read source registers of due links and send them.
// RULE_09: consecutive sources to consecutive destinations, twenty at most.
// RULE_10: at most ten descriptors, any mix of fast and slow.
// RULE_11: no limit on links addressing one target node.
// RULE_12: small variant indices 0 to 79; large variant 0 to 99.
// RULE_13: resident program may rewrite descriptors at run time.
// RULE_14: fast links every sync, slow links every N-th sync.
// RULE_15: sync counter wraps at the ratio to mark slow-link syncs.
`default_nettype none
module csls_scheduler #(
  parameter int TB_1000_CYC = csls_pkg::TB_1000_CYC,
  parameter int TB_1380_CYC = csls_pkg::TB_1380_CYC,
  parameter int TB_1840_CYC = csls_pkg::TB_1840_CYC,
  parameter int TB_2560_CYC = csls_pkg::TB_2560_CYC,
  parameter int FIFO_DEPTH  = csls_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // network side
  input  wire logic        syncIn,
  output logic             syncOut,
  output logic             txValid,
  input  wire logic        txReady,
  output csls_pkg::csls_tx_s txWord
);
  import csls_pkg::*;

  if (TB_1000_CYC < 2 || TB_1380_CYC < 2 || TB_1840_CYC < 2 ||
      TB_2560_CYC < 2 || TB_1000_CYC > 65535 || TB_1380_CYC > 65535 ||
      TB_1840_CYC > 65535 || TB_2560_CYC > 65535) begin : gBadParam
    $error("csls_scheduler time base counts must lie in 2..65535");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_SEND = 2'b10
  } csls_state_e;

  // configuration and status state
  logic        syncNodeEn;
  logic        syncTakeoverEn;
  logic        smallVariant;
  csls_tb_e    tbMode;
  logic [2:0]  switchingFreqSelector;
  logic [7:0]  lossLimit;
  logic [15:0] rate;
  logic        takeover;
  logic        syncLost;
  logic        badLink;
  logic        overrun;
  logic [6:0]  slowCnt;
  logic [15:0] syncCount;
  logic [7:0]  lossCnt;
  logic [15:0] tickCnt;
  logic        tick;
  logic [16:0] elapsed;
  csls_state_e state;
  logic [3:0]  linkPtr;
  logic [4:0]  wordPtr;
  logic        slowPass;
  csls_link_s  links [MAX_LINKS];
  logic [31:0] linkSourceRegister [NUM_SRC];

  // apb decode
  wire        setup   = psel & ~penable;
  wire        doWrite = psel & penable & pready & pwrite;
  wire        isCtrl  = paddr == CTRL_OFS;
  wire        isRate  = paddr == RATE_OFS;
  wire        isStat  = paddr == STAT_OFS;
  wire        aligned = paddr[1:0] == 2'b00;
  wire        isLink  = aligned && paddr >= LINK_BASE && paddr < LINK_END;
  wire        isSrc   = aligned && paddr >= SRC_BASE && paddr < SRC_END;
  wire        mapped  = isCtrl | isRate | isStat | isLink | isSrc;
  wire [11:0] linkOfs = paddr - LINK_BASE;
  wire [11:0] srcOfs  = paddr - SRC_BASE;
  wire [3:0]  linkIdx = linkOfs[5:2];
  wire [6:0]  srcIdx  = srcOfs[8:2];

  // descriptor write check against the variant's index range
  csls_link_s wrLink;
  assign wrLink = csls_link_s'(pwdata & LINK_MASK);
  wire [7:0] idxLimit  = smallVariant ? 8'(SMALL_LIMIT) : 8'(LARGE_LIMIT);
  wire [7:0] srcSpan   = 8'(wrLink.src) + 8'(wrLink.count);
  wire [7:0] destSpan  = 8'(wrLink.dest) + 8'(wrLink.count);
  wire       linkOk    = wrLink.count <= 5'(MAX_WORDS) &&  // see RULE_09
                         srcSpan <= idxLimit &&            // see RULE_12
                         destSpan <= idxLimit;             // see RULE_12
  wire       linkWrite = doWrite & isLink;

  wire [31:0] ctrlWord = {8'h00, lossLimit, 5'h00, switchingFreqSelector,
                          2'b00, tbMode, 1'b0, smallVariant, syncTakeoverEn,
                          syncNodeEn};
  wire        generating = syncNodeEn | takeover;
  wire        busy       = state != ST_IDLE;
  wire [31:0] statWord   = {syncCount, 1'b0, slowCnt, 3'b000, busy, overrun,
                            badLink, syncLost, generating};
  wire [31:0] rdMux = isCtrl ? ctrlWord :
                      isRate ? {16'h0000, rate} :
                      isStat ? statWord :
                      isLink ? 32'(links[linkIdx]) :
                      isSrc  ? linkSourceRegister[srcIdx] : 32'h0000_0000;

  // one wait-free access phase: pready follows the setup cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= (mapped & ~pwrite) ? rdMux : 32'h0000_0000;
      end
    end
  end

  // rate decode, two decimal digits each
  wire [6:0]  fastPeriodDigits = 7'(rate[7:4]) * 7'd10 +
                                 7'(rate[3:0]);              // see RULE_01
  wire [6:0]  ratioDigits      = 7'(rate[15:12]) * 7'd10 +
                                 7'(rate[11:8]);             // see RULE_01
  wire [16:0] reqUs = 17'(fastPeriodDigits) * 17'(US_PER_MS);

  // time base selection
  wire        selLong = switchingFreqSelector == 3'h1 ||
                        switchingFreqSelector == 3'h3;       // see RULE_03
  wire [15:0] tbCyc = tbMode == TB_SEL  ? (selLong ? 16'(TB_1840_CYC)
                                                   : 16'(TB_1380_CYC)) :
                      tbMode == TB_2560 ? 16'(TB_2560_CYC)
                                        : 16'(TB_1000_CYC);  // see RULE_02
  wire [11:0] tbUs  = tbMode == TB_SEL  ? (selLong ? 12'(TB_1840_US)
                                                   : 12'(TB_1380_US)) :
                      tbMode == TB_2560 ? 12'(TB_2560_US)
                                        : 12'(TB_1000_US);   // see RULE_02
  wire        tbIsMs  = tbUs == 12'(TB_1000_US);
  wire        tickEnd = tickCnt >= tbCyc - 16'h0001;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tickCnt <= 16'h0000;
      tick    <= 1'b0;
    end else begin
      tickCnt <= tickEnd ? 16'h0000 : tickCnt + 16'h0001;
      tick    <= tickEnd;
    end
  end

  // sync generation: elapsed time in us, compared after each tick
  wire [16:0] elapsedNext = elapsed + 17'(tbUs);
  wire        periodDone  = tbIsMs ? elapsedNext >= reqUs
                                   : elapsedNext > reqUs;    // see RULE_04
  wire        genFire = generating & tick & (fastPeriodDigits != 7'h00) &
                        periodDone;
  // a generating node ignores foreign syncs so two sources never double up
  wire        syncEvt = generating ? genFire : syncIn;       // see RULE_05

  always_ff @(posedge mclk) begin
    if (rst || !generating) begin
      elapsed <= 17'h00000;
    end else if (tick) begin
      elapsed <= genFire ? 17'h00000 : elapsedNext;          // see RULE_04
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      syncOut <= 1'b0;
    end else begin
      syncOut <= genFire;
    end
  end

  // loss watch counts ticks since the last foreign sync
  wire lossHit = syncTakeoverEn & ~syncNodeEn & (lossLimit != 8'h00) &
                 (lossCnt >= lossLimit) & ~takeover;         // see RULE_06

  always_ff @(posedge mclk) begin
    if (rst) begin
      lossCnt  <= 8'h00;
      takeover <= 1'b0;
    end else begin
      if (syncIn) begin
        lossCnt <= 8'h00;
      end else if (tick && lossCnt != 8'hFF) begin
        lossCnt <= lossCnt + 8'h01;
      end
      if (!syncTakeoverEn || syncNodeEn || syncIn) begin
        takeover <= 1'b0;
      end else if (lossHit) begin
        takeover <= 1'b1;                                    // see RULE_06
      end
    end
  end

  // slow-link marker wraps at the ratio; ratio 0 or 1 makes every sync slow
  wire [6:0] slowInc  = slowCnt + 7'h01;
  wire       slowDue  = slowCnt == 7'h00;                    // see RULE_15

  always_ff @(posedge mclk) begin
    if (rst) begin
      slowCnt   <= 7'h00;
      syncCount <= 16'h0000;
    end else if (syncEvt) begin
      slowCnt   <= (slowInc >= ratioDigits) ? 7'h00 : slowInc; // see RULE_15
      syncCount <= syncCount + 16'h0001;
    end
  end

  // configuration registers; sticky flags let a new event beat the clear
  wire statClr = doWrite & isStat;

  always_ff @(posedge mclk) begin
    if (rst) begin
      syncNodeEn            <= 1'b0;
      syncTakeoverEn        <= 1'b0;
      smallVariant          <= 1'b0;
      tbMode                <= TB_1MS;
      switchingFreqSelector <= 3'h0;
      lossLimit             <= LOSS_RST;
      rate                  <= RATE_RST;
      syncLost              <= 1'b0;
      badLink               <= 1'b0;
      overrun               <= 1'b0;
    end else begin
      if (doWrite && isCtrl) begin
        syncNodeEn            <= pwdata[CTRL_SYNC_BIT];
        syncTakeoverEn        <= pwdata[CTRL_TAKE_BIT];
        smallVariant          <= pwdata[CTRL_SMALL_BIT];
        tbMode                <= csls_tb_e'(pwdata[CTRL_TB_LSB +: 2]);
        switchingFreqSelector <= pwdata[CTRL_FSEL_LSB +: 3];
        lossLimit             <= pwdata[CTRL_LOSS_LSB +: 8];
      end
      if (doWrite && isRate) begin
        rate <= pwdata[15:0];
      end
      syncLost <= lossHit | (syncLost & ~(statClr & pwdata[STAT_LOST_BIT]));
      badLink  <= (linkWrite & ~linkOk) |
                  (badLink & ~(statClr & pwdata[STAT_BADLINK_BIT]));
      overrun  <= (syncEvt & busy) |
                  (overrun & ~(statClr & pwdata[STAT_OVERRUN_BIT]));
    end
  end

  // descriptors: run-time rewrites take effect at once, even on the slot being sent
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < MAX_LINKS; i++) begin
        links[i] <= csls_link_s'(32'h0000_0000);
      end
    end else if (linkWrite && linkOk) begin
      links[linkIdx] <= wrLink;                              // see RULE_13
    end
  end

  always_ff @(posedge mclk) begin
    if (doWrite && isSrc) begin
      linkSourceRegister[srcIdx] <= pwdata;
    end
  end

  // scan engine
  csls_link_s cur;
  assign cur = links[linkPtr];                               // see RULE_07
  wire       linkDue  = (cur.count != 5'h00) &&
                        (!cur.slow || slowPass);             // see RULE_14
  wire       lastLink = linkPtr == 4'(MAX_LINKS - 1);        // see RULE_10
  wire       lastWord = (wordPtr + 5'h01) >= cur.count;
  wire [6:0] rdIdx    = cur.src + 7'(wordPtr);               // see RULE_09
  wire       pushValid = state == ST_SEND;
  logic      pushReady;
  csls_tx_s  pushWord;

  // no filter on the target: any number of links may share one node
  wire [31:0] pushData = (rdIdx < 7'(NUM_SRC)) ? linkSourceRegister[rdIdx]
                                               : 32'h0000_0000; // see RULE_08
  assign pushWord = {cur.target, cur.dest + 7'(wordPtr), lastWord,
                     pushData};                      // see RULE_09 RULE_11

  always_ff @(posedge mclk) begin
    if (rst) begin
      state    <= ST_IDLE;
      linkPtr  <= 4'h0;
      wordPtr  <= 5'h00;
      slowPass <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (syncEvt) begin                                 // see RULE_05
            slowPass <= slowDue;                             // see RULE_14
            linkPtr  <= 4'h0;
            state    <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          wordPtr <= 5'h00;
          if (linkDue) begin
            state <= ST_SEND;                                // see RULE_08
          end else if (lastLink) begin
            state <= ST_IDLE;
          end else begin
            linkPtr <= linkPtr + 4'h1;
          end
        end
        ST_SEND: begin
          if (pushReady) begin
            if (!lastWord) begin
              wordPtr <= wordPtr + 5'h01;                    // see RULE_09
            end else if (lastLink) begin
              state <= ST_IDLE;
            end else begin
              linkPtr <= linkPtr + 4'h1;
              state   <= ST_SCAN;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // the buffer's ready stalls the engine, so a slow network backs up here
  logic [$bits(csls_tx_s)-1:0] fifoOut;

  csls_fifo #(
    .WIDTH ($bits(csls_tx_s)),
    .DEPTH (FIFO_DEPTH)
  ) uTxFifo (
    .clk      (mclk),
    .rst      (rst),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushWord),
    .outValid (txValid),
    .outReady (txReady),
    .outData  (fifoOut)
  );

  assign txWord = csls_tx_s'(fifoOut);

endmodule : csls_scheduler
`default_nettype wire

// ---- tb_top.sv ----
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import csls_pkg::*;
  localparam int          TB1 = 10;
  localparam int          TB2 = 14;
  localparam int          TB3 = 18;
  localparam int          TB4 = 26;
  localparam logic [31:0] CRST = 32'h0064_0000;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        syncIn, syncOut, txValid, txReady, stall;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, v;
  logic [31:0] srcVal [0:99];
  logic [31:0] destMem [0:99];
  csls_tx_s    txWord;
  int          failures, cmp_count, cyc, wordCnt, lastCnt, n, c4, w0, l0;
  logic [31:0] genCtrl [0:8] = '{32'h0064_0001, 32'h0064_0011,
    32'h0064_0111, 32'h0064_0211, 32'h0064_0311, 32'h0064_0411,
    32'h0064_0021, 32'h0064_0031, 32'h0064_0711};

  csls_scheduler #(
    .TB_1000_CYC(TB1), .TB_1380_CYC(TB2), .TB_1840_CYC(TB3),
    .TB_2560_CYC(TB4), .FIFO_DEPTH(8)
  ) i_csls_scheduler (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .syncIn(syncIn), .syncOut(syncOut),
    .txValid(txValid), .txReady(txReady), .txWord(txWord));
  csls_node_model i_csls_node_model (
    .mclk(mclk), .rst(rst), .stall(stall), .txValid(txValid),
    .txReady(txReady), .txWord(txWord), .destMem(destMem));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (txValid === 1'b1 && txReady === 1'b1) begin
      wordCnt++;
      if (txWord.last === 1'b1)
        lastCnt++;
      if (txWord.dest == 7'd70)
        chk(32'(txWord.target), 32'h22);
      if (txWord.dest == 7'd5)
        chk(32'(txWord.target), 32'h21);
    end
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
  endtask : do_reset

  // pulse a foreign sync, then poll until the scan and fifo are empty
  task automatic sync_and_wait();
    @(posedge mclk);
    syncIn <= 1'b1;
    @(posedge mclk);
    syncIn <= 1'b0;
    do begin
      rd(STAT_OFS);
    end while (rdv[4] !== 1'b0 || txValid !== 1'b0);
  endtask : sync_and_wait

  // cycles between two generated sync pulses
  task automatic gap(output int g);
    do begin
      @(posedge mclk);
    end while (syncOut !== 1'b1);
    g = 0;
    do begin
      @(posedge mclk);
      g++;
    end while (syncOut !== 1'b1 && g < 500);
  endtask : gap

  function automatic logic [31:0] lnk(input int t, s, c, d, r);
    return {t[7:0], s[0], 2'h0, c[4:0], 1'h0, d[6:0], 1'h0, r[6:0]};
  endfunction : lnk

  // rate setting stays 1005: five milliseconds fast period
  function automatic int exp_gap(input logic [31:0] c);
    int us;
    int cy;
    us = 1000;
    cy = TB1;
    if (c[5:4] == 2'h1) begin
      us = (c[10:8] == 3'h1 || c[10:8] == 3'h3) ? 1840 : 1380;
      cy = (us == 1840) ? TB3 : TB2;
    end else if (c[5:4] == 2'h2) begin
      us = 2560;
      cy = TB4;
    end
    return (us == 1000 ? 5 : 5000 / us + 1) * cy;
  endfunction : exp_gap

  // ratio of two: slow links ride on every second sync, first included
  function automatic int exp_words(input int k);
    return 2 + c4 + ((k % 2 == 0) ? 20 : 0);
  endfunction : exp_words

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, syncIn, stall} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {failures, cmp_count, cyc, wordCnt, lastCnt} = '0;
    n = $urandom(88);
    do_reset();
    rd(CTRL_OFS);
    chk(rdv, CRST);
    rd(RATE_OFS);
    chk(rdv, 32'h0000_1005);
    for (int i = 0; i < 2; i++) begin
      rd(i ? 12'h002 : 12'h0C0);
      chk({31'h0, err}, 32'h1);
      chk(rdv, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      wr(STAT_OFS, 32'h0000_000E);
      wr(CTRL_OFS, CRST | (i % 2 ? 32'h4 : 32'h0));
      wr(LINK_BASE + 12'h004, 32'h0);
      v = (i == 0) ? lnk(1, 0, 21, 0, 0) :
          (i == 3) ? lnk(1, 0, 3, 77, 10) : lnk(1, 0, 3, 0, 78);
      wr(LINK_BASE + 12'h004, v);
      rd(LINK_BASE + 12'h004);
      chk(rdv, i >= 2 ? v : 32'h0);
      rd(STAT_OFS);
      chk({31'h0, rdv[2]}, {31'h0, i < 2});
    end
    for (int i = 0; i < 9; i++) begin
      wr(CTRL_OFS, CRST);
      wr(CTRL_OFS, genCtrl[i]);
      gap(n);
      chk(n, exp_gap(genCtrl[i]));
    end
    wr(CTRL_OFS, 32'h0008_0002);
    gap(n);
    chk(n, exp_gap(32'h0008_0002));
    rd(STAT_OFS);
    chk({30'h0, rdv[1:0]}, 32'h3);
    sync_and_wait();
    chk({31'h0, rdv[0]}, 32'h0);
    do_reset();
    wordCnt = 0;
    wr(RATE_OFS, 32'h0000_0205);
    for (int i = 0; i < 100; i++) begin
      srcVal[i] = $urandom;
      wr(SRC_BASE + 12'(4 * i), srcVal[i]);
    end
    c4 = 1 + $urandom % 5;
    wr(LINK_BASE, lnk(8'h21, 0, 2, 5, 3));
    wr(LINK_BASE + 12'h010, lnk($urandom % 256, 0, c4, 30, 20));
    v = lnk(8'h22, 1, 20, 70, 60);
    wr(LINK_BASE + 12'h024, v);
    rd(LINK_BASE + 12'h024);
    chk(rdv, v);
    repeat (100) @(posedge mclk);
    chk(wordCnt, 0);
    stall <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      w0 = wordCnt;
      l0 = lastCnt;
      sync_and_wait();
      chk(wordCnt - w0, exp_words(k));
      chk(lastCnt - l0, k % 2 ? 2 : 3);
    end
    for (int j = 0; j < 20; j++)
      chk(destMem[70 + j], srcVal[60 + j]);
    chk(destMem[6], srcVal[4]);
    chk(destMem[29 + c4], srcVal[19 + c4]);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
